// *** common/der_map.svh ***
// der_map.svh: constants of the datagram echo responder
// assumes: included by bare name from package and core files
`ifndef DER_MAP_SVH
`define DER_MAP_SVH

`define DER_ECHO_SOCKET   8'h04
`define DER_ECHO_TYPE     8'h04
`define DER_FUNC_REQUEST  8'h01
`define DER_FUNC_REPLY    8'h02
`define DER_LEN_W         10
`define DER_BUF_DEPTH     600
`define DER_BUF_AW        10

`endif

// *** common/der_pkg.sv ***
// der_pkg.sv: types of the datagram echo responder
// assumes: der_map.svh on the include path
`include "der_map.svh"
package der_pkg;

   typedef enum logic [1:0] {
      DER_IDLE = 2'b00,
      DER_RECV = 2'b01,
      DER_SEND = 2'b11,
      DER_DROP = 2'b10
   } der_state_e;

   typedef struct packed {
      der_state_e              state;
      logic [`DER_BUF_AW-1:0]  wr_cnt;
      logic [`DER_BUF_AW-1:0]  rd_cnt;
      logic [7:0]              src_net_hi;
      logic [7:0]              src_net_lo;
      logic [7:0]              src_node;
      logic [7:0]              src_socket;
      logic                    keep;
      logic                    tx_valid;
      logic [7:0]              tx_data;
      logic                    tx_last;
      logic                    tx_start;
      logic                    rx_ready;
      logic                    rd_pend;
   } der_st_s;

endpackage : der_pkg

// *** core/der_buf.sv ***
// der_buf.sv: byte store holding one datagram payload
// assumes: single clock, one write and one registered read per cycle
`timescale 1ns/10ps
`default_nettype none
`include "der_map.svh"
module der_buf (
   // clock
   input  wire logic                   clk,
   // write side
   input  wire logic                   wr_en,
   input  wire logic [`DER_BUF_AW-1:0] wr_addr,
   input  wire logic [7:0]             wr_data,
   // read side
   input  wire logic [`DER_BUF_AW-1:0] rd_addr,
   output logic      [7:0]             rd_data_ff
);

   logic [7:0] mem [0:`DER_BUF_DEPTH-1];

   // no reset: address 0 is never written; its read data is replaced by the reply code
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
   end

endmodule : der_buf
`default_nettype wire

// *** core/der_echo.sv ***
// der_echo.sv: echo responder on the node's fixed echo socket
// assumes: delivery layer gives one datagram at a time as a byte stream
// with header fields valid on the first byte; replies leave as a stream.
//
// Overview of operation
// - serve only datagrams delivered to socket 4
// - drop type not 4 or first byte not code 1, no response
// - first payload byte is the echo function code
// - code 1 becomes 2 and the datagram goes back for sending
// - reply goes to source network, node and socket of the request
// - payload bytes after the code return unchanged
`timescale 1ns/10ps
`default_nettype none
`include "der_map.svh"
module der_echo (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // receive stream from the delivery layer
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_last,
   input  wire logic [7:0]  rx_dst_socket,
   input  wire logic [7:0]  rx_type,
   input  wire logic [15:0] rx_src_net,
   input  wire logic [7:0]  rx_src_node,
   input  wire logic [7:0]  rx_src_socket,
   output logic             rx_ready_ff,
   // transmit stream to the delivery layer
   output logic             tx_valid_ff,
   output logic [7:0]       tx_data_ff,
   output logic             tx_last_ff,
   output logic             tx_start_ff,
   output logic [15:0]      tx_dst_net_ff,
   output logic [7:0]       tx_dst_node_ff,
   output logic [7:0]       tx_dst_socket_ff,
   output logic [7:0]       tx_src_socket_ff,
   output logic [7:0]       tx_type_ff,
   input  wire logic        tx_ready
);

   der_pkg::der_st_s st_ff;
   der_pkg::der_st_s nxt_st;
   logic [7:0]       buf_rd_data;
   logic             rx_take;
   logic             buf_wr;
   logic [`DER_BUF_AW-1:0] rd_addr;

   assign rx_take = rx_valid && st_ff.rx_ready;
   assign buf_wr  = rx_take && (st_ff.state == der_pkg::DER_RECV);
   // read address: rd_cnt, advanced in the send state each time a byte read is issued
   assign rd_addr = st_ff.rd_cnt;

   der_buf u_buf (
      .clk        (clk),
      .wr_en      (buf_wr),
      .wr_addr    (st_ff.wr_cnt),
      .wr_data    (rx_data),
      .rd_addr    (rd_addr),
      .rd_data_ff (buf_rd_data)
   );

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff.state)
         der_pkg::DER_IDLE: begin
            nxt_st.rx_ready = 1'b1;
            nxt_st.wr_cnt   = '0;
            nxt_st.rd_cnt   = '0;
            if (rx_take) begin
               nxt_st.src_net_hi = rx_src_net[15:8];
               nxt_st.src_net_lo = rx_src_net[7:0];
               nxt_st.src_node   = rx_src_node;
               nxt_st.src_socket = rx_src_socket;
               // header fields and first byte judged together
               nxt_st.keep = (rx_dst_socket == `DER_ECHO_SOCKET)
                  && (rx_type == `DER_ECHO_TYPE)
                  && (rx_data == `DER_FUNC_REQUEST);
               // a first byte that is also last still yields a reply
               nxt_st.wr_cnt = `DER_BUF_AW'(1);
               if (rx_last) begin
                  nxt_st.rx_ready = !nxt_st.keep;
                  nxt_st.state = nxt_st.keep ? der_pkg::DER_SEND
                                             : der_pkg::DER_IDLE;
               end else begin
                  nxt_st.state = nxt_st.keep ? der_pkg::DER_RECV
                                             : der_pkg::DER_DROP;
               end
            end
         end
         der_pkg::DER_RECV: begin
            if (rx_take) begin
               nxt_st.wr_cnt = st_ff.wr_cnt + `DER_BUF_AW'(1);
               if (rx_last || st_ff.wr_cnt ==
                   `DER_BUF_AW'(`DER_BUF_DEPTH - 1)) begin
                  nxt_st.rx_ready = 1'b0;
                  nxt_st.state = rx_last ? der_pkg::DER_SEND
                                         : der_pkg::DER_DROP;
               end
            end
         end
         der_pkg::DER_DROP: begin
            // swallow rest of a rejected datagram, nothing sent
            nxt_st.rx_ready = 1'b1;
            if (rx_take && rx_last) begin
               nxt_st.state = der_pkg::DER_IDLE;
            end
         end
         der_pkg::DER_SEND: begin
            nxt_st.rx_ready = 1'b0;
            if (!st_ff.tx_valid || tx_ready) begin
               // start stands with the first byte until the sink takes it
               nxt_st.tx_start = 1'b0;
               if (st_ff.tx_valid && st_ff.tx_last) begin
                  nxt_st.tx_valid = 1'b0;
                  nxt_st.tx_last  = 1'b0;
                  nxt_st.rd_pend  = 1'b0;
                  nxt_st.state    = der_pkg::DER_IDLE;
                  nxt_st.rx_ready = 1'b1;
               end else if (st_ff.rd_pend) begin
                  nxt_st.tx_valid = 1'b1;
                  nxt_st.tx_start = (st_ff.rd_cnt == `DER_BUF_AW'(1));
                  // byte 0 replaced, the rest copied verbatim
                  nxt_st.tx_data = (st_ff.rd_cnt == `DER_BUF_AW'(1))
                     ? `DER_FUNC_REPLY : buf_rd_data;
                  nxt_st.tx_last = (st_ff.rd_cnt == st_ff.wr_cnt);
                  nxt_st.rd_pend = 1'b0;
               end else begin
                  // one cycle of bubble per byte: read data is registered
                  nxt_st.tx_valid = 1'b0;
                  nxt_st.rd_pend  = 1'b1;
                  nxt_st.rd_cnt   = st_ff.rd_cnt + `DER_BUF_AW'(1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{state: der_pkg::DER_IDLE, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rx_ready_ff      = st_ff.rx_ready;
   assign tx_valid_ff      = st_ff.tx_valid;
   assign tx_data_ff       = st_ff.tx_data;
   assign tx_last_ff       = st_ff.tx_last;
   assign tx_start_ff      = st_ff.tx_start;
   assign tx_dst_net_ff    = {st_ff.src_net_hi, st_ff.src_net_lo};
   assign tx_dst_node_ff   = st_ff.src_node;
   assign tx_dst_socket_ff = st_ff.src_socket;
   assign tx_src_socket_ff = `DER_ECHO_SOCKET;
   assign tx_type_ff       = `DER_ECHO_TYPE;

endmodule : der_echo
`default_nettype wire

// *** verification/der_echo_props.sv ***
// der_echo_props.sv: port checks; bound into der_echo, one clock domain
`timescale 1ns/10ps
`default_nettype none
module der_echo_props (
   // watched ports
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_last,
   input wire logic [7:0] rx_dst_socket,
   input wire logic [7:0] rx_type,
   input wire logic       rx_ready_ff,
   input wire logic       tx_valid_ff,
   input wire logic [7:0] tx_data_ff,
   input wire logic       tx_start_ff,
   input wire logic [7:0] tx_dst_socket_ff,
   input wire logic       tx_ready
);
   logic first_ff, ok_ff;
   wire  take = rx_valid && rx_ready_ff;
   // header and code count on the first byte only
   wire  ok = first_ff ? rx_dst_socket == 8'h04 && rx_type == 8'h04
              && rx_data == 8'h01 : ok_ff;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) {first_ff, ok_ff} <= 2'h2;
      else if (take) {first_ff, ok_ff} <= {rx_last, ok};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_last_in; take && rx_last; endsequence
   AST_KEEP: assert property (s_last_in ##0 ok |->
      ##[1:8] tx_start_ff) else $error("no reply");
   AST_DROP: assert property (s_last_in ##0 !ok |=>
      !tx_valid_ff [*8]) else $error("dropped datagram answered");
   AST_CODE: assert property (tx_start_ff |->
      tx_valid_ff && tx_data_ff == 8'h02) else $error("bad reply code");
   AST_HOLD: assert property (tx_valid_ff && !tx_ready |=>
      tx_valid_ff && $stable(tx_data_ff)) else $error("reply byte moved");
   AST_ADDR: assert property (tx_valid_ff && !tx_start_ff |->
      $stable(tx_dst_socket_ff)) else $error("reply address moved");
   AST_START: assert property (tx_start_ff && !tx_ready |=>
      tx_start_ff) else $error("start dropped while stalled");
   AST_ONCE: assert property (tx_start_ff && tx_ready |=>
      !tx_start_ff) else $error("start repeated");
   AST_BUSY: assert property (tx_valid_ff |->
      !rx_ready_ff) else $error("request taken during reply");
endmodule : der_echo_props
bind der_echo der_echo_props u_props (.*);
`default_nettype wire

// *** verification/der_client.sv ***
// der_client.sv: remote echo client; the bench sets the header fields
`timescale 1ns/10ps
`default_nettype none
module der_client (
   // request and reply streams
   input  wire logic       clk,
   input  wire logic       rx_ready_ff,
   input  wire logic       tx_valid_ff,
   input  wire logic [7:0] tx_data_ff,
   input  wire logic       tx_last_ff,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last,
   output logic            tx_ready
);
   logic [7:0] got[$];
   bit         slow;
   int         last_at;
   initial {rx_valid, rx_data, rx_last, tx_ready, slow} = '0;
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         {rx_valid, rx_data, rx_last} = {1'h1, b[i], i == b.size() - 1};
         @(posedge clk iff rx_ready_ff);
         #1;
      end
      // released data shows the inverse, never a stale copy
      {rx_valid, rx_data, rx_last} = {1'h0, ~rx_data, 1'h0};
   endtask : send
   always @(posedge clk) begin
      if (tx_valid_ff && tx_ready) begin
         got.push_back(tx_data_ff);
         if (tx_last_ff) last_at = got.size();
      end
      #1 tx_ready = slow ? !tx_ready : 1'h1;
   end
endmodule : der_client
`default_nettype wire

// *** verification/der_echo_test.sv ***
// der_echo_test.sv: self-checking bench; der_client is the far side
`timescale 1ns/10ps
`default_nettype none
module der_echo_test;
   typedef struct packed {logic [7:0] sock, typ, code; logic keep;} der_row_s;
   der_row_s rows[4] = '{'{8'h04, 8'h04, 8'h01, 1'h1}, '{8'h05, 8'h04, 8'h01,
      1'h0}, '{8'h04, 8'h03, 8'h01, 1'h0}, '{8'h04, 8'h04, 8'h02, 1'h0}};
   logic        clk = 0, rst_n = 0, rx_valid, rx_last, rx_ready_ff, tx_ready;
   logic        tx_valid_ff, tx_last_ff, tx_start_ff;
   logic [7:0]  tx_type_ff;
   logic [7:0]  rx_data, rx_dst_socket, rx_type, rx_src_node, rx_src_socket;
   logic [7:0]  tx_data_ff, tx_dst_node_ff, tx_dst_socket_ff, tx_src_socket_ff;
   logic [15:0] rx_src_net = 16'h0123, tx_dst_net_ff;
   int          num_errors = 0, total_checks = 0, cyc = 0;
   der_echo   dut (.*);
   der_client cl (.*);
   always #5 clk = ~clk;
   always @(posedge clk) if (++cyc == 3000) finish_test();
   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) num_errors++;
      if (seen !== exp) $display("Error %s exp %h seen %h", what, exp, seen);
   endtask : check
   task automatic finish_test();
      num_errors += int'(cyc >= 3000);
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   task automatic run(input der_row_s r, input int n);
      logic [7:0] q[$];
      q = {r.code};
      for (int i = 1; i < n; i++) q.push_back(8'hA0 ^ 8'(i));
      {rx_dst_socket, rx_type} = {r.sock, r.typ};
      rx_src_socket = rx_src_socket + 8'h01;
      cl.got.delete();
      cl.last_at = 0;
      cl.send(q);
      #(10 * (4 * n + 20)); // own reply window, then judge
      check("count", cl.got.size(), r.keep ? n : 0);
      foreach (cl.got[i])
         check("byte", cl.got[i], i ? q[i] : 8'h02);
      check("last", cl.last_at, r.keep ? n : 0);
      if (r.keep) check("dest", tx_dst_socket_ff, rx_src_socket);
      if (r.keep) check("node", tx_dst_node_ff, rx_src_node);
      if (r.keep) check("net", tx_dst_net_ff, rx_src_net);
      $display("done code %h sock %h type %h", r.code, r.sock, r.typ);
   endtask : run
   initial begin
      {rx_dst_socket, rx_type, rx_src_node, rx_src_socket} = 32'h04042180;
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      check("idle", {tx_valid_ff, tx_type_ff}, 9'h004);
      check("src", tx_src_socket_ff, 8'h04);
      foreach (rows[i]) run(rows[i], 3);
      // stalled sink with shortest and longer requests
      cl.slow = 1;
      run(rows[0], 1);
      run(rows[0], 9);
      // reset while idle between runs, then a request must still be served
      rst_n = 0;
      #10 check("reset", {rx_ready_ff, tx_valid_ff, tx_start_ff}, 3'h0);
      rst_n = 1;
      run(rows[0], 2);
      finish_test();
   end
endmodule : der_echo_test
`default_nettype wire
